// ===== pkg/lcdc_consts.svh
// Function
// - Command 1011xxxx loads page 0..8
// - Page 8 stores only bit D0
// - Page change leaves display untouched
// - Column loaded as high/low nibbles
// - Data access increments column, page never
// - Status: busy, order, off, reset, zeros
// - Busy refuses commands; host may wait
// - Order flag 1 means normal mapping
// - Off flag 1 means display off
// - Reset flag during rst_n pin initialization, not after nrst
// - Data write stores, advances column
// - Data read pipelined; dummy after load
// - Serial host cannot read RAM
// - Order command D0 selects reversed
// - Inverse command D0 selects inverse
// - All-points lights all, overrides inverse
// - All-points while off enters power save
// - Duty select from D0
// - Duty+1 line shows page 8 D0
// - Inversion count k gives k+1 lines
// - Release stops inversion, keeps count
// - Read-modify-write: reads hold column
// - End restores saved column
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH

`define LCDC_CLK_NS     100
`define LCDC_RST_NS     1000
`define LCDC_BUSY_NS    300
`define LCDC_RST_CYC    ((`LCDC_RST_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)
`define LCDC_BUSY_CYC   ((`LCDC_BUSY_NS + `LCDC_CLK_NS - 1) / `LCDC_CLK_NS)
`define LCDC_PAGES      9
`define LCDC_COLS       166
`define LCDC_COL_END    8'hA6
`define LCDC_IND_PAGE   4'h8
`define LCDC_NL_INIT    4'hF
`define LCDC_DUTY_INIT  1'b1
`define LCDC_ST_BUSY    7
`define LCDC_ST_ORDER   6
`define LCDC_ST_OFF     5
`define LCDC_ST_RESET   4
`define LCDC_OP_PAGE    4'hB
`define LCDC_OP_COLHI   4'h1
`define LCDC_OP_COLLO   4'h0
`define LCDC_OP_NLINE   4'h3
`define LCDC_OP_ORDER   7'h50
`define LCDC_OP_INV     7'h53
`define LCDC_OP_ALLON   7'h52
`define LCDC_OP_DUTY    7'h54
`define LCDC_OP_DUTYP1  7'h55
`define LCDC_OP_NLREL   8'h20
`define LCDC_OP_RMW     8'hE0
`define LCDC_OP_END     8'hEE

`endif

// ===== pkg/lcdc_pkg.sv
`default_nettype none
package lcdc_pkg;

  typedef struct packed {
    logic       rst_n;
    logic       sel;
    logic       rd_n;
    logic       wr_n;
    logic       serial;
    logic [7:0] data;
  } lcdc_pins_t;

  typedef struct packed {
    logic       seg_rev;
    logic       inverse;
    logic       all_on;
    logic       psave;
    logic       duty;
    logic       duty_p1;
    logic       nl_en;
    logic [3:0] nl_cnt;
  } lcdc_mode_t;

  typedef struct packed {
    lcdc_pins_t s1;
    lcdc_pins_t s2;
    logic       prev_rd_n;
    logic       prev_wr_n;
    logic [3:0] page;
    logic [7:0] col;
    logic [7:0] col_save;
    logic       rmw;
    lcdc_mode_t mode;
    logic [3:0] busy_cnt;
    logic [3:0] rst_cnt;
    logic [7:0] rd_latch;
    logic [7:0] dout;
    logic       doe;
    logic [7:0] scan_q;
    logic       extra_q;
  } lcdc_state_t;

endpackage
`default_nettype wire

// ===== rtl/lcdc_cmd_decoder.sv
`include "lcdc_consts.svh"
`default_nettype none
module lcdc_cmd_decoder
  import lcdc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire lcdc_pins_t pins,
  input  wire logic       disp_on,
  input  wire logic [3:0] scan_page,
  input  wire logic [7:0] scan_col,
  output logic [7:0]      data_out,
  output logic            data_oe,
  output lcdc_mode_t      mode,
  output logic [7:0]      scan_data,
  output logic            extra_common_output
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [10:0] ram_idx(input logic [3:0] pg, input logic [7:0] cl);
    ram_idx = 11'(pg * `LCDC_COLS) + 11'(cl);
  endfunction

  // Saturates at the end address so a long burst cannot wrap into column 0
  function automatic logic [7:0] col_inc(input logic [7:0] cl);
    col_inc = (cl < `LCDC_COL_END) ? cl + 8'h01 : cl;
  endfunction

  localparam lcdc_mode_t MODE_INIT = '{duty: `LCDC_DUTY_INIT, nl_cnt: `LCDC_NL_INIT,
                                       default: '0};
  localparam lcdc_pins_t PINS_IDLE = '{rst_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
  localparam lcdc_state_t ST_INIT = '{s1: PINS_IDLE, s2: PINS_IDLE, prev_rd_n: 1'b1,
                                      prev_wr_n: 1'b1, mode: MODE_INIT, default: '0};

  // ----------------------------------------
  // State and RAM
  // ----------------------------------------
  lcdc_state_t st_r;
  lcdc_state_t st_nxt;
  logic [7:0]  ram [0:`LCDC_PAGES*`LCDC_COLS-1];

  logic        wr_go;
  logic        rd_go;
  logic        busy;
  logic        cmd_go;
  logic        ram_we;
  logic [10:0] idx;
  logic [7:0]  ram_q;
  logic [7:0]  wr_byte;
  logic [7:0]  cmd_byte;
  logic [7:0]  status;

  always_comb begin
    wr_go   = st_r.s2.wr_n & ~st_r.prev_wr_n;
    rd_go   = ~st_r.s2.rd_n & st_r.prev_rd_n;
    busy    = (st_r.busy_cnt != 4'h0) | (st_r.rst_cnt != 4'h0);
    cmd_go  = wr_go & ~st_r.s2.sel & ~busy;
    idx     = ram_idx(st_r.page, st_r.col);
    ram_q   = ram[idx];
    if (st_r.page == `LCDC_IND_PAGE) begin
      ram_q = {7'h00, ram_q[0]};
    end
    // Commands decode the raw byte; the page 8 mask is for RAM only
    cmd_byte = st_r.s2.data;
    wr_byte = st_r.s2.data;
    if (st_r.page == `LCDC_IND_PAGE) begin
      wr_byte = {7'h00, st_r.s2.data[0]};
    end
    ram_we  = wr_go & st_r.s2.sel & ~busy & (st_r.col < `LCDC_COL_END);
    status  = 8'h00;
    status[`LCDC_ST_BUSY]  = busy;
    status[`LCDC_ST_ORDER] = ~st_r.mode.seg_rev;
    status[`LCDC_ST_OFF]   = ~disp_on;
    status[`LCDC_ST_RESET] = st_r.rst_cnt != 4'h0;
  end

  always_ff @(posedge clk) begin
    if (ce && ram_we) begin
      ram[idx] <= wr_byte;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.s1        = pins;
    st_nxt.s2        = st_r.s1;
    st_nxt.prev_rd_n = st_r.s2.rd_n;
    st_nxt.prev_wr_n = st_r.s2.wr_n;
    st_nxt.doe       = ~st_r.s2.rd_n;
    // Page change only retargets host access; scan uses its own address
    st_nxt.scan_q    = ram[ram_idx(scan_page, scan_col)];
    st_nxt.extra_q   = ram[ram_idx(`LCDC_IND_PAGE, scan_col)][0];
    if (st_r.busy_cnt != 4'h0) begin
      st_nxt.busy_cnt = st_r.busy_cnt - 4'h1;
    end
    if (st_r.rst_cnt != 4'h0) begin
      st_nxt.rst_cnt = st_r.rst_cnt - 4'h1;
    end

    if (wr_go && !busy) begin
      st_nxt.busy_cnt = 4'(`LCDC_BUSY_CYC);
    end

    if (ram_we) begin
      st_nxt.col = col_inc(st_r.col);
    end

    if (rd_go) begin
      if (!st_r.s2.sel) begin
        st_nxt.dout = status;
      end else if (st_r.s2.serial) begin
        st_nxt.dout = 8'h00;
      end else begin
        // Output the byte fetched by the previous read, then prefetch
        st_nxt.dout = st_r.rd_latch;
        if (!busy) begin
          st_nxt.rd_latch = ram_q;
          st_nxt.busy_cnt = 4'(`LCDC_BUSY_CYC);
          if (!st_r.rmw) begin
            st_nxt.col = col_inc(st_r.col);
          end
        end
      end
    end

    if (cmd_go) begin
      casez (cmd_byte)
        8'b1011_????: begin
          if (cmd_byte[3:0] <= `LCDC_IND_PAGE) begin
            st_nxt.page = cmd_byte[3:0];
          end
        end
        8'b0001_????: st_nxt.col = {cmd_byte[3:0], st_r.col[3:0]};
        8'b0000_????: st_nxt.col = {st_r.col[7:4], cmd_byte[3:0]};
        8'b0011_????: begin
          st_nxt.mode.nl_cnt = cmd_byte[3:0];
          st_nxt.mode.nl_en  = 1'b1;
        end
        `LCDC_OP_NLREL: st_nxt.mode.nl_en = 1'b0;
        `LCDC_OP_RMW: begin
          if (!st_r.rmw) begin
            st_nxt.rmw      = 1'b1;
            st_nxt.col_save = st_r.col;
          end
        end
        `LCDC_OP_END: begin
          if (st_r.rmw) begin
            st_nxt.rmw = 1'b0;
            st_nxt.col = st_r.col_save;
          end
        end
        default: begin
          unique case (cmd_byte[7:1])
            `LCDC_OP_ORDER:  st_nxt.mode.seg_rev = cmd_byte[0];
            `LCDC_OP_INV:    st_nxt.mode.inverse = cmd_byte[0];
            `LCDC_OP_ALLON: begin
              st_nxt.mode.all_on = cmd_byte[0];
              st_nxt.mode.psave  = cmd_byte[0] & ~disp_on;
            end
            `LCDC_OP_DUTY:   st_nxt.mode.duty    = cmd_byte[0];
            `LCDC_OP_DUTYP1: st_nxt.mode.duty_p1 = cmd_byte[0];
            default: ;
          endcase
        end
      endcase
    end

    // Display turned back on ends power save
    if (disp_on) begin
      st_nxt.mode.psave = 1'b0;
    end

    if (!st_r.s2.rst_n) begin
      st_nxt.page     = 4'h0;
      st_nxt.col      = 8'h00;
      st_nxt.rmw      = 1'b0;
      st_nxt.mode     = MODE_INIT;
      st_nxt.busy_cnt = 4'h0;
      st_nxt.rst_cnt  = 4'(`LCDC_RST_CYC);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_INIT;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  always_comb begin
    data_out            = st_r.dout;
    data_oe             = st_r.doe;
    mode                = st_r.mode;
    scan_data           = st_r.scan_q;
    extra_common_output = st_r.extra_q;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_cmd;
    ce && cmd_go && st_r.s2.rst_n;
  endsequence

  sequence s_data_rd;
    ce && rd_go && st_r.s2.sel && !busy;
  endsequence

  a_page_load: assert property (s_cmd ##0 (cmd_byte[7:4] == 4'hB && cmd_byte[3:0] <= 4'h8)
    |=> st_r.page == $past(cmd_byte[3:0])) else $error("page not loaded");

  a_page8_bit: assert property (ce && ram_we && st_r.page == 4'h8
    |=> ram[$past(idx)][7:1] == 7'h00) else $error("page 8 upper bits stored");

  a_col_advance: assert property (ce && ram_we
    |=> st_r.col == $past(st_r.col) + 8'h01) else $error("column not advanced");

  a_rmw_hold: assert property (s_data_rd ##0 (st_r.rmw && !st_r.s2.serial)
    |=> st_r.col == $past(st_r.col)) else $error("column moved in rmw read");

  a_end_restore: assert property (s_cmd ##0 (cmd_byte == 8'hEE && st_r.rmw)
    |=> !st_r.rmw && st_r.col == $past(st_r.col_save)) else $error("column not restored");

  a_status_byte: assert property (ce && rd_go && !st_r.s2.sel
    |=> data_out[3:0] == 4'h0 && data_out[6] == !$past(st_r.mode.seg_rev))
    else $error("status byte wrong");

  a_busy_refuse: assert property (ce && wr_go && busy && st_r.s2.rst_n
    |=> st_r.page == $past(st_r.page) && st_r.mode == $past(st_r.mode))
    else $error("command taken while busy");

  a_psave_entry: assert property (s_cmd ##0 (cmd_byte == 8'hA5 && !disp_on)
    |=> mode.psave && mode.all_on) else $error("power save not entered");

  a_serial_noread: assert property (ce && rd_go && st_r.s2.sel && st_r.s2.serial
    |=> data_out == 8'h00 && st_r.col == $past(st_r.col)) else $error("serial read served");

  a_reset_flag: assert property (ce && !st_r.s2.rst_n ##1 ce
    |-> status[4] && busy) else $error("reset flag missing");

  // ----------------------------------------
  // Command and data path checks
  // ----------------------------------------
  sequence s_status_rd;
    ce && rd_go && !st_r.s2.sel;
  endsequence

  sequence s_data_wr;
    ce && ram_we;
  endsequence

  a_colhi_load: assert property (s_cmd ##0 (cmd_byte[7:4] == 4'h1)
    |=> st_r.col == {$past(cmd_byte[3:0]), $past(st_r.col[3:0])})
    else $error("column high nibble not loaded");

  a_collo_load: assert property (s_cmd ##0 (cmd_byte[7:4] == 4'h0)
    |=> st_r.col == {$past(st_r.col[7:4]), $past(cmd_byte[3:0])})
    else $error("column low nibble not loaded");

  a_nline_set: assert property (s_cmd ##0 (cmd_byte[7:4] == 4'h3)
    |=> mode.nl_en && mode.nl_cnt == $past(cmd_byte[3:0]))
    else $error("inversion count not stored");

  a_nline_release: assert property (s_cmd ##0 (cmd_byte == 8'h20)
    |=> !mode.nl_en && mode.nl_cnt == $past(mode.nl_cnt))
    else $error("inversion release wrong");

  a_order_set: assert property (s_cmd ##0 (cmd_byte[7:1] == 7'h50)
    |=> mode.seg_rev == $past(cmd_byte[0]))
    else $error("segment order not set");

  a_inverse_set: assert property (s_cmd ##0 (cmd_byte[7:1] == 7'h53)
    |=> mode.inverse == $past(cmd_byte[0]))
    else $error("inverse flag not set");

  a_allon_set: assert property (s_cmd ##0 (cmd_byte[7:1] == 7'h52)
    |=> mode.all_on == $past(cmd_byte[0]) && mode.inverse == $past(mode.inverse))
    else $error("all points flag wrong");

  a_duty_set: assert property (s_cmd ##0 (cmd_byte[7:1] == 7'h54)
    |=> mode.duty == $past(cmd_byte[0]))
    else $error("duty not set");

  a_dutyp1_set: assert property (s_cmd ##0 (cmd_byte[7:1] == 7'h55)
    |=> mode.duty_p1 == $past(cmd_byte[0]))
    else $error("duty plus one not set");

  a_unknown_ignored: assert property (s_cmd ##0 (cmd_byte == 8'hFF)
    |=> st_r.page == $past(st_r.page) && st_r.col == $past(st_r.col) && st_r.rmw == $past(st_r.rmw))
    else $error("unknown command changed state");

  a_data_store: assert property (s_data_wr
    |=> ram[$past(idx)] == $past(wr_byte))
    else $error("data byte not stored");

  a_rd_pipeline: assert property (s_data_rd ##0 !st_r.s2.serial
    |=> data_out == $past(st_r.rd_latch) && st_r.rd_latch == $past(ram_q))
    else $error("read pipeline wrong");

  a_status_off: assert property (s_status_rd
    |=> data_out[5] == !$past(disp_on) && data_out[4] == $past(st_r.rst_cnt != 4'h0))
    else $error("status off or reset flag wrong");

  a_oe_follow: assert property (ce && rd_go
    |=> data_oe)
    else $error("bus drive missing on read");

endmodule // lcdc_cmd_decoder
`default_nettype wire

// ===== bench/lcdc_host_model.sv
`default_nettype none
module lcdc_host_model
  import lcdc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] rd_bus,
  input  wire logic       rd_oe,
  output lcdc_pins_t      pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // Host bus cycles
  // ----------------------------------------------------------------
  initial begin
    pins = {1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h00};
  end

  // Strobe low 4, data kept 4 past rise, then idle: clears busy
  task automatic acc(input logic s, input logic r, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    #5;
    pins.sel  = s;
    pins.data = d;
    if (r) pins.rd_n = 1'b0;
    else pins.wr_n = 1'b0;
    repeat (4) @(posedge clk);
    q = rd_oe ? rd_bus : 8'hXX;
    #5;
    pins.rd_n = 1'b1;
    pins.wr_n = 1'b1;
    repeat (4) @(posedge clk);
    #5;
    pins.data = ~d; // Released bus shows no stale byte
    repeat (4) @(posedge clk);
    #5;
  endtask

  // Two command writes with no recovery gap: the second lands while busy
  task automatic burst_cmd(input logic [7:0] d0, input logic [7:0] d1);
    @(posedge clk);
    #5;
    pins.sel  = 1'b0;
    pins.data = d0;
    pins.wr_n = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    pins.wr_n = 1'b1;
    @(posedge clk);
    #5;
    pins.data = d1;
    pins.wr_n = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    pins.wr_n = 1'b1;
    repeat (10) @(posedge clk);
    #5;
  endtask

  task automatic hw_reset();
    @(posedge clk);
    #5;
    pins.rst_n = 1'b0;
    repeat (12) @(posedge clk);
    #5;
    pins.rst_n = 1'b1;
  endtask

  task automatic set_serial(input logic v);
    @(posedge clk);
    #5;
    pins.serial = v;
  endtask
endmodule // lcdc_host_model
`default_nettype wire

// ===== bench/lcd_ram_command_decoder_tb_top.sv
`default_nettype none
module lcd_ram_command_decoder_tb_top
  import lcdc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, nrst, disp_on, extra, oe, ce;
  logic [3:0]  scan_page, p;
  logic [7:0]  scan_col, dout, scan_data, q, c, r;
  logic [7:0]  d [4];
  logic [31:0] lfsr_r;
  logic [6:0]  ops [5] = '{7'h50, 7'h53, 7'h52, 7'h54, 7'h55};
  lcdc_pins_t  pins;
  lcdc_mode_t  mode, em;
  int          miscompares, samples_checked;

  lcdc_cmd_decoder u_lcdc_cmd_decoder (.clk(clk), .nrst(nrst), .ce(ce), .pins(pins),
    .disp_on(disp_on), .scan_page(scan_page), .scan_col(scan_col), .data_out(dout),
    .data_oe(oe), .mode(mode), .scan_data(scan_data), .extra_common_output(extra));
  lcdc_host_model u_lcdc_host_model (.clk(clk), .rd_bus(dout), .rd_oe(oe), .pins(pins));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] rnd();
    for (int i = 0; i < 8; i++) begin
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
    end
    return lfsr_r[7:0];
  endfunction
  task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_mode(input lcdc_mode_t g);
    samples_checked++;
    if (g !== em) begin
      miscompares++;
      $display("ERROR mode expected %h seen %h", em, g);
    end
  endtask
  task automatic cmd(input logic [7:0] b);
    u_lcdc_host_model.acc(1'b0, 1'b0, b, q);
  endtask
  task automatic wr(input logic [7:0] b);
    u_lcdc_host_model.acc(1'b1, 1'b0, b, q);
  endtask
  task automatic rd(input logic s);
    u_lcdc_host_model.acc(s, 1'b1, 8'h00, q);
  endtask
  task automatic setcol(input logic [7:0] v);
    cmd({4'h1, v[7:4]});
    cmd({4'h0, v[3:0]});
  endtask
  task automatic stop_test();
    $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock, watchdog, scenarios
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++; // Hung sequence
    stop_test();
  end
  initial begin
    {nrst, disp_on, scan_page, scan_col, miscompares, samples_checked} = '0;
    lfsr_r = 32'hA6FFBA72;
    ce = 1'b1;
    repeat (12) @(posedge clk);
    #5;
    nrst = 1'b1;
    u_lcdc_host_model.hw_reset();
    rd(1'b0);
    chk_byte("status_rst", 8'hF0, q);
    em = '0;
    em.duty = 1'b1;
    em.nl_cnt = 4'hF;
    chk_mode(mode);
    rd(1'b0);
    chk_byte("status_off", 8'h60, q);
    disp_on = 1'b1;
    rd(1'b0);
    chk_byte("status_on", 8'h40, q);
    for (int i = 0; i < 20; i++) begin
      r = rnd();
      case (r[6:4] % 5)
        0: em.seg_rev = r[0];
        1: em.inverse = r[0];
        2: em.all_on = r[0];
        3: em.duty = r[0];
        default: em.duty_p1 = r[0];
      endcase
      cmd({ops[r[6:4] % 5], r[0]});
      chk_mode(mode);
      rd(1'b0);
      chk_byte("status", {1'b0, ~em.seg_rev, 6'h00}, q);
    end
    u_lcdc_host_model.burst_cmd(8'hA7, 8'hA6);
    em.inverse = 1'b1;
    chk_mode(mode);
    r = rnd() | 8'h01;
    cmd({4'h3, r[3:0]});
    {em.nl_en, em.nl_cnt} = {1'b1, r[3:0]};
    chk_mode(mode);
    cmd(8'h20);
    em.nl_en = 1'b0;
    chk_mode(mode);
    cmd(8'hFF);
    chk_mode(mode);
    cmd(8'hA4);
    disp_on = 1'b0;
    cmd(8'hA5);
    {em.all_on, em.psave} = 2'b11;
    chk_mode(mode);
    cmd(8'hA4);
    {em.all_on, em.psave} = 2'b00;
    chk_mode(mode);
    disp_on = 1'b1;
    r = rnd();
    p = {1'b0, r[2:0]};
    c = rnd() & 8'h7F;
    cmd({4'hB, p});
    setcol(c);
    for (int i = 0; i < 4; i++) begin
      d[i] = rnd();
      wr(d[i]);
    end
    setcol(c);
    rd(1'b1);
    for (int i = 0; i < 4; i++) begin
      rd(1'b1);
      chk_byte("ram", d[i], q);
    end
    {scan_page, scan_col} = {p, c + 8'h01};
    cmd(8'hB8);
    chk_byte("scan", d[1], scan_data);
    ce = 1'b0;
    scan_col = c;
    repeat (4) @(posedge clk);
    #5;
    chk_byte("scan_frozen", d[1], scan_data);
    ce = 1'b1;
    repeat (2) @(posedge clk);
    #5;
    chk_byte("scan_moved", d[0], scan_data);
    setcol(c);
    wr(8'hFF);
    setcol(c);
    rd(1'b1);
    rd(1'b1);
    chk_byte("page8", 8'h01, q);
    {scan_page, scan_col} = {4'h8, c};
    repeat (3) @(posedge clk);
    chk_byte("extra", 8'h01, {7'h00, extra});
    cmd({4'hB, p});
    setcol(c);
    cmd(8'hE0);
    rd(1'b1);
    rd(1'b1);
    wr(8'h5A);
    wr(8'hA5);
    cmd(8'hEE);
    rd(1'b1);
    rd(1'b1);
    chk_byte("rmw0", 8'h5A, q);
    rd(1'b1);
    chk_byte("rmw1", 8'hA5, q);
    u_lcdc_host_model.set_serial(1'b1);
    rd(1'b1);
    chk_byte("serial", 8'h00, q);
    u_lcdc_host_model.set_serial(1'b0);
    stop_test();
  end
endmodule // lcd_ram_command_decoder_tb_top
`default_nettype wire
